/* hw/tcm_pkg.sv */
// Package of constants for the transfer controller mode and stop logic
package tcm_pkg;
  localparam int TCM_NUM_ENABLE_REGS = 4;
  localparam int TCM_NUM_SETS = 24;
  localparam int TCM_COUNT_W = 8;
  // Register byte offsets
  localparam logic [7:0] TCM_OFF_ENABLE0 = 8'h00;
  localparam logic [7:0] TCM_OFF_ENABLE3 = 8'h0C;
  localparam logic [7:0] TCM_OFF_MODE = 8'h10;
  localparam logic [7:0] TCM_OFF_RPT_IE = 8'h14;
  localparam logic [7:0] TCM_OFF_ADDR_INC = 8'h18;
  localparam logic [7:0] TCM_OFF_STATUS = 8'h1C;
  localparam logic [7:0] TCM_OFF_MASK = 8'h20;
  localparam logic [7:0] TCM_OFF_SEL = 8'h24;
  localparam logic [7:0] TCM_OFF_COUNT = 8'h28;
  localparam logic [7:0] TCM_OFF_RELOAD = 8'h2C;
  localparam logic [7:0] TCM_OFF_ADDR = 8'h30;
  localparam logic [7:0] TCM_OFF_BUSY = 8'h34;
  // Reset values
  localparam logic [TCM_COUNT_W-1:0] TCM_COUNT_RST = 8'h00;
  localparam logic [31:0] TCM_WORD_RST = 32'h0000_0000;
  // Cycles one transfer spends in the move state; the memory bus stays busy one cycle more
  localparam int TCM_XFER_CYCLES = 2;
  typedef enum logic [1:0] {
    TCM_IDLE,
    TCM_MOVE,
    TCM_DONE
  } tcm_state_t;
endpackage : tcm_pkg

/* hw/tcm_channel.sv */
// One control data set: transfer count, reload value and area address
module tcm_channel #(
  parameter int COUNT_W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Software writes
  input wire logic wr_count,
  input wire logic wr_reload,
  input wire logic wr_addr,
  input wire logic [31:0] wdata,
  // Transfer completion
  input wire logic done,
  input wire logic repeat_mode,
  input wire logic addr_inc,
  // State
  output logic [COUNT_W-1:0] count,
  output logic [COUNT_W-1:0] reload,
  output logic [15:0] addr,
  output logic last
);
  import tcm_pkg::*;
  logic [COUNT_W-1:0] next_count;
  logic [COUNT_W-1:0] next_reload;
  logic [15:0] next_addr;

  assign last = (count == COUNT_W'(1));

  always_comb begin
    next_count = count;
    next_reload = reload;
    next_addr = addr;
    if (wr_reload) begin
      next_reload = wdata[COUNT_W-1:0];
    end
    if (wr_addr) begin
      next_addr = wdata[15:0];
    end
    if (wr_count) begin
      next_count = wdata[COUNT_W-1:0];
    end else if (done) begin
      if (last && repeat_mode) begin
        next_count = reload;
      end else begin
        next_count = count - COUNT_W'(1);
      end
      if (addr_inc && !wr_addr) begin
        next_addr = addr + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      reload <= '0;
      addr <= 16'h0000;
    end else begin
      count <= next_count;
      reload <= next_reload;
      addr <= next_addr;
    end
  end
endmodule : tcm_channel

/* hw/tcm_top.sv */
// Transfer controller start, stop, reload and interrupt logic
module tcm_top #(
  parameter int NUM_SETS = tcm_pkg::TCM_NUM_SETS,
  parameter int COUNT_W = tcm_pkg::TCM_COUNT_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Peripheral activation requests, one per set
  input wire logic [NUM_SETS-1:0] act_req,
  // Memory bus: transfer in progress for a set
  output logic mem_busy,
  output logic [4:0] mem_set,
  output logic [15:0] mem_addr,
  // Per-source interrupt pulses towards the CPU
  output logic [NUM_SETS-1:0] cpu_irq,
  // Summary interrupt
  output logic irq
);
  import tcm_pkg::*;

  // Enable bits: four registers of eight bits each
  logic [31:0] act_en;
  logic [31:0] next_act_en;
  logic [31:0] mode_rpt, next_mode_rpt;
  logic [31:0] rpt_ie, next_rpt_ie;
  logic [31:0] addr_inc, next_addr_inc;
  logic [31:0] status, next_status;
  logic [31:0] mask, next_mask;
  logic [4:0] sel, next_sel;
  logic [NUM_SETS-1:0] cpu_irq_n;

  tcm_state_t state, next_state;
  logic [4:0] cur, next_cur;
  logic [1:0] cyc, next_cyc;
  logic [31:0] rdata_n;
  logic ack, next_ack;

  logic [COUNT_W-1:0] count [NUM_SETS];
  logic [COUNT_W-1:0] reload [NUM_SETS];
  logic [15:0] addr [NUM_SETS];
  logic [NUM_SETS-1:0] last;
  logic [NUM_SETS-1:0] done_v;

  logic wr, rd;
  // Writes land at the edge where waitrequest is low
  assign wr = avs_write && ack;
  assign rd = avs_read && !ack;
  // One wait cycle on every access
  assign avs_waitrequest = (avs_read || avs_write) && !ack;

  genvar g;
  generate
    for (g = 0; g < NUM_SETS; g++) begin : g_set
      tcm_channel #(.COUNT_W(COUNT_W)) u_ch (
        .clock(clock),
        .rstn(rstn),
        .wr_count(wr && avs_address == TCM_OFF_COUNT
          && sel == 5'(g)),
        .wr_reload(wr && avs_address == TCM_OFF_RELOAD
          && sel == 5'(g)),
        .wr_addr(wr && avs_address == TCM_OFF_ADDR && sel == 5'(g)),
        .wdata(avs_writedata),
        .done(done_v[g]),
        .repeat_mode(mode_rpt[g]),
        .addr_inc(addr_inc[g]),
        .count(count[g]),
        .reload(reload[g]),
        .addr(addr[g]),
        .last(last[g])
      );
      assign done_v[g] = (state == TCM_DONE) && (cur == 5'(g));
    end
  endgenerate

  // Lowest pending enabled source wins
  logic found;
  logic [4:0] pick;
  always_comb begin
    found = 1'b0;
    pick = 5'h00;
    for (int i = NUM_SETS - 1; i >= 0; i--) begin
      if (act_en[i] && act_req[i]) begin
        found = 1'b1;
        pick = 5'(i);
      end
    end
  end

  // Transfer sequencer
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_cyc = cyc;
    case (state)
      TCM_IDLE: begin
        if (found) begin
          next_state = TCM_MOVE;
          next_cur = pick;
          next_cyc = 2'(TCM_XFER_CYCLES - 1);
        end
      end
      TCM_MOVE: begin
        if (cyc == 2'h0) begin
          next_state = TCM_DONE;
        end else begin
          next_cyc = cyc - 2'h1;
        end
      end
      TCM_DONE: begin
        next_state = TCM_IDLE;
      end
      default: begin
        next_state = TCM_IDLE;
      end
    endcase
  end

  // Completion: enable clearing, interrupts, register writes
  logic fin_last, fin_irq, fin_stop;
  always_comb begin
    next_act_en = act_en;
    next_mode_rpt = mode_rpt;
    next_rpt_ie = rpt_ie;
    next_addr_inc = addr_inc;
    next_mask = mask;
    next_sel = sel;
    next_status = status;
    cpu_irq_n = '0;
    fin_last = (state == TCM_DONE) && last[cur];
    // Normal: always; repeat: only when repeat interrupt enabled
    fin_irq = fin_last && (!mode_rpt[cur] || rpt_ie[cur]);
    fin_stop = fin_irq;
    if (wr) begin
      if (avs_address >= TCM_OFF_ENABLE0
          && avs_address <= TCM_OFF_ENABLE3) begin
        next_act_en[avs_address[3:2]*8 +: 8] = avs_writedata[7:0];
      end else if (avs_address == TCM_OFF_MODE) begin
        next_mode_rpt = avs_writedata;
      end else if (avs_address == TCM_OFF_RPT_IE) begin
        next_rpt_ie = avs_writedata;
      end else if (avs_address == TCM_OFF_ADDR_INC) begin
        next_addr_inc = avs_writedata;
      end else if (avs_address == TCM_OFF_STATUS) begin
        next_status = status & ~avs_writedata;
      end else if (avs_address == TCM_OFF_MASK) begin
        next_mask = avs_writedata;
      end else if (avs_address == TCM_OFF_SEL) begin
        next_sel = avs_writedata[4:0];
      end
    end
    // Hardware stop and set win over a same-cycle software write
    if (fin_stop) begin
      next_act_en[cur] = 1'b0;
    end
    if (fin_irq) begin
      cpu_irq_n[cur] = 1'b1;
      next_status[cur] = 1'b1;
    end
    next_act_en[31:NUM_SETS] = '0;
    next_status[31:NUM_SETS] = '0;
  end

  // Only existing sets are read back; other indices read zero
  logic sel_ok;
  assign sel_ok = (32'(sel) < 32'(NUM_SETS));

  // Read mux
  always_comb begin
    next_ack = (avs_read || avs_write) && !ack;
    rdata_n = 32'h0000_0000;
    if (avs_address >= TCM_OFF_ENABLE0 && avs_address <= TCM_OFF_ENABLE3) begin
      rdata_n[7:0] = act_en[avs_address[3:2]*8 +: 8];
    end else if (avs_address == TCM_OFF_MODE) begin
      rdata_n = mode_rpt;
    end else if (avs_address == TCM_OFF_RPT_IE) begin
      rdata_n = rpt_ie;
    end else if (avs_address == TCM_OFF_ADDR_INC) begin
      rdata_n = addr_inc;
    end else if (avs_address == TCM_OFF_STATUS) begin
      rdata_n = status;
    end else if (avs_address == TCM_OFF_MASK) begin
      rdata_n = mask;
    end else if (avs_address == TCM_OFF_SEL) begin
      rdata_n[4:0] = sel;
    end else if (avs_address == TCM_OFF_COUNT && sel_ok) begin
      rdata_n[COUNT_W-1:0] = count[sel];
    end else if (avs_address == TCM_OFF_RELOAD && sel_ok) begin
      rdata_n[COUNT_W-1:0] = reload[sel];
    end else if (avs_address == TCM_OFF_ADDR && sel_ok) begin
      rdata_n[15:0] = addr[sel];
    end else if (avs_address == TCM_OFF_BUSY) begin
      rdata_n[0] = mem_busy;
    end
    if (!rd) begin
      rdata_n = avs_readdata;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= TCM_IDLE;
      cur <= 5'h00;
      cyc <= 2'h0;
      act_en <= TCM_WORD_RST;
      mode_rpt <= TCM_WORD_RST;
      rpt_ie <= TCM_WORD_RST;
      addr_inc <= TCM_WORD_RST;
      status <= TCM_WORD_RST;
      mask <= TCM_WORD_RST;
      sel <= 5'h00;
      ack <= 1'b0;
      avs_readdata <= TCM_WORD_RST;
      cpu_irq <= '0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      cyc <= next_cyc;
      act_en <= next_act_en;
      mode_rpt <= next_mode_rpt;
      rpt_ie <= next_rpt_ie;
      addr_inc <= next_addr_inc;
      status <= next_status;
      mask <= next_mask;
      sel <= next_sel;
      ack <= next_ack;
      avs_readdata <= rdata_n;
      cpu_irq <= cpu_irq_n;
    end
  end

  assign mem_busy = (state != TCM_IDLE);
  assign mem_set = cur;
  assign mem_addr = addr[cur];
  assign irq = |(status & mask);

  a_normal_stop: assert property (
    @(posedge clock) disable iff (!rstn)
    (state == TCM_DONE && last[cur] && !mode_rpt[cur])
    |=> (act_en[$past(cur)] == 1'b0 && cpu_irq[$past(cur)]))
    else $error("normal mode final transfer did not stop and interrupt");
  a_repeat_run: assert property (
    @(posedge clock) disable iff (!rstn)
    (state == TCM_DONE && last[cur] && mode_rpt[cur] && !rpt_ie[cur])
    |=> cpu_irq == '0)
    else $error("repeat mode interrupted without enable");
  a_repeat_keep: assert property (
    @(posedge clock) disable iff (!rstn)
    (state == TCM_DONE && last[cur] && mode_rpt[cur] && !rpt_ie[cur]
     && !(wr && avs_address <= TCM_OFF_ENABLE3))
    |=> act_en[$past(cur)] == $past(act_en[cur]))
    else $error("repeat mode stopped without interrupt enable");
  a_repeat_reload: assert property (
    @(posedge clock) disable iff (!rstn)
    (state == TCM_DONE && last[cur] && mode_rpt[cur]
     && !(wr && avs_address == TCM_OFF_COUNT))
    |=> count[$past(cur)] == $past(reload[cur]))
    else $error("repeat mode count not reloaded");
  a_count_dec: assert property (
    @(posedge clock) disable iff (!rstn)
    (state == TCM_DONE && !last[cur]
     && !(wr && avs_address == TCM_OFF_COUNT))
    |=> count[$past(cur)] == $past(count[cur]) - COUNT_W'(1))
    else $error("count not decremented");
  a_addr_step: assert property (
    @(posedge clock) disable iff (!rstn)
    (state == TCM_DONE && addr_inc[cur]
     && !(wr && avs_address == TCM_OFF_ADDR))
    |=> addr[$past(cur)] == $past(addr[cur]) + 16'h0001)
    else $error("area address did not advance");
  a_addr_hold: assert property (
    @(posedge clock) disable iff (!rstn)
    (state == TCM_DONE && !addr_inc[cur]
     && !(wr && avs_address == TCM_OFF_ADDR))
    |=> addr[$past(cur)] == $past(addr[cur]))
    else $error("fixed area address moved");
  a_start_move: assert property (
    @(posedge clock) disable iff (!rstn)
    (state == TCM_IDLE && found) |=> state == TCM_MOVE ##2 state == TCM_DONE)
    else $error("enabled request did not start a transfer");
  a_irq_level: assert property (
    @(posedge clock) disable iff (!rstn)
    $rose(cpu_irq[cur]) && mask[cur] |-> irq)
    else $error("interrupt output not raised");
  a_irq_status: assert property (
    @(posedge clock) disable iff (!rstn)
    cpu_irq[cur] |-> status[cur])
    else $error("interrupt pulse without status bit");
  a_irq_pulse: assert property (
    @(posedge clock) disable iff (!rstn)
    cpu_irq != '0 |=> cpu_irq == '0)
    else $error("interrupt request longer than one cycle");
  a_bus_wait: assert property (
    @(posedge clock) disable iff (!rstn)
    $rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("first bus cycle was not stretched");
  a_bus_answer: assert property (
    @(posedge clock) disable iff (!rstn)
    avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer took more than one wait cycle");
endmodule : tcm_top

/* bench/tcm_src_model.sv */
// Activation request sources and CPU interrupt and bus activity counters
module tcm_src_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Bench command
  input wire logic [23:0] want,
  // Design side
  input wire logic mem_busy,
  input wire logic [4:0] mem_set,
  input wire logic [23:0] cpu_irq,
  output logic [23:0] act_req
);
  int xfers [24];
  int irqs [24];
  logic busy_q;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      act_req <= '0;
      busy_q <= 1'b0;
      for (int i = 0; i < 24; i++) begin
        xfers[i] <= 0;
        irqs[i] <= 0;
      end
    end else begin
      act_req <= want;
      busy_q <= mem_busy;
      if (mem_busy && !busy_q) begin
        xfers[mem_set] <= xfers[mem_set] + 1;
      end
      for (int i = 0; i < 24; i++) begin
        irqs[i] <= irqs[i] + int'(cpu_irq[i]);
      end
    end
  end
endmodule : tcm_src_model

/* bench/tcm_top_bench.sv */
// Self-checking bench for the transfer controller stop and reload logic
module tcm_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import tcm_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wd;
  logic [31:0] rdat;
  logic wreq;
  logic [23:0] want;
  logic [23:0] act_req;
  logic [23:0] cpu_irq;
  logic busy;
  logic [4:0] mset;
  logic irq;
  logic [15:0] maddr;
  logic [31:0] v;
  int bad_count;
  int compares;
  int n;

  always #25 clock = ~clock;

  tcm_top DUT (.clock(clock), .rstn(rstn), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .act_req(act_req), .mem_busy(busy),
    .mem_set(mset), .mem_addr(maddr), .cpu_irq(cpu_irq), .irq(irq));

  tcm_src_model model (.clock(clock), .rstn(rstn), .want(want),
    .mem_busy(busy), .mem_set(mset), .cpu_irq(cpu_irq), .act_req(act_req));

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic give_up();
    bad_count++;
    $display("mismatch at %0t: wait timed out", $time);
    test_done();
  endtask : give_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    logic got;
    @(posedge clock);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    k = 0;
    got = 1'b0;
    while (!got && k < 50) begin
      @(posedge clock);
      k++;
      got = (wreq === 1'b0);
    end
    if (!got) give_up();
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic wrt(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, v);
  endtask : wrt

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, v);
    check(v, exp);
  endtask : rdc

  task automatic irq_is(input logic exp);
    @(negedge clock);
    check({31'h0, irq}, {31'h0, exp});
  endtask : irq_is

  task automatic wait_xfers(input int s, input int cnt);
    int k;
    k = 0;
    while (model.xfers[s] < cnt && k < 2000) begin
      @(negedge clock);
      k++;
    end
    if (k >= 2000) give_up();
  endtask : wait_xfers

  // Waits for eight quiet bus cycles in a row
  task automatic settle();
    int k;
    int q;
    k = 0;
    q = 0;
    while (q < 8 && k < 500) begin
      @(negedge clock);
      k++;
      q = busy ? 0 : q + 1;
    end
    if (q < 8) give_up();
  endtask : settle

  initial begin
    adr = 8'h00;
    rd = 1'b0;
    wr = 1'b0;
    wd = 32'h0000_0000;
    want = 24'h00_0000;
    bad_count = 0;
    compares = 0;
    n = 0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    rdc(TCM_OFF_ENABLE0, 32'h0000_0000);
    rdc(TCM_OFF_COUNT, 32'h0000_0000);
    rdc(TCM_OFF_STATUS, 32'h0000_0000);
    rdc(8'hFC, 32'h0000_0000);
    wrt(8'h04, 32'hFFFF_FFFF);
    rdc(8'h04, 32'h0000_00FF);
    wrt(8'h04, 32'h0000_0000);
    wrt(TCM_OFF_ENABLE3, 32'hFFFF_FFFF);
    rdc(TCM_OFF_ENABLE3, 32'h0000_0000);
    rdc(TCM_OFF_BUSY, 32'h0000_0000);
    $display("test registers done");
    // Normal mode, count of three, request raised before enabling
    wrt(TCM_OFF_SEL, 32'h0000_0000);
    wrt(TCM_OFF_COUNT, 32'h0000_0003);
    want <= 24'h00_0001;
    settle();
    check(model.xfers[0], 32'h0000_0000);
    wrt(TCM_OFF_ENABLE0, 32'h0000_0001);
    wait_xfers(0, 3);
    settle();
    want <= 24'h00_0000;
    check(model.xfers[0], 32'h0000_0003);
    check(model.irqs[0], 32'h0000_0001);
    rdc(TCM_OFF_ENABLE0, 32'h0000_0000);
    rdc(TCM_OFF_COUNT, 32'h0000_0000);
    rdc(TCM_OFF_STATUS, 32'h0000_0001);
    rdc(TCM_OFF_BUSY, 32'h0000_0000);
    irq_is(1'b0);
    wrt(TCM_OFF_MASK, 32'h0000_0001);
    irq_is(1'b1);
    wrt(TCM_OFF_STATUS, 32'h0000_0001);
    irq_is(1'b0);
    rdc(TCM_OFF_STATUS, 32'h0000_0000);
    $display("test normal mode done");
    // Repeat mode without interrupt keeps running
    wrt(TCM_OFF_SEL, 32'h0000_0001);
    wrt(TCM_OFF_COUNT, 32'h0000_0002);
    wrt(TCM_OFF_RELOAD, 32'h0000_0002);
    wrt(TCM_OFF_ADDR, 32'h0000_1234);
    wrt(TCM_OFF_MODE, 32'h0000_0006);
    wrt(TCM_OFF_ENABLE0, 32'h0000_0002);
    want <= 24'h00_0002;
    wait_xfers(1, 5);
    want <= 24'h00_0000;
    settle();
    n = model.xfers[1];
    check(model.irqs[1], 32'h0000_0000);
    rdc(TCM_OFF_ENABLE0, 32'h0000_0002);
    rdc(TCM_OFF_COUNT, 32'(2 - n % 2));
    rdc(TCM_OFF_ADDR, 32'h0000_1234);
    wrt(TCM_OFF_ENABLE0, 32'h0000_0000);
    wrt(TCM_OFF_STATUS, 32'hFFFF_FFFF);
    $display("test repeat mode done");
    // Repeat mode with interrupt stops after reload; address advances
    wrt(TCM_OFF_SEL, 32'h0000_0002);
    wrt(TCM_OFF_COUNT, 32'h0000_0002);
    wrt(TCM_OFF_RELOAD, 32'h0000_0005);
    wrt(TCM_OFF_ADDR, 32'h0000_0100);
    wrt(TCM_OFF_ADDR_INC, 32'h0000_0004);
    wrt(TCM_OFF_RPT_IE, 32'h0000_0004);
    wrt(TCM_OFF_MASK, 32'h0000_0004);
    wrt(TCM_OFF_ENABLE0, 32'h0000_0004);
    want <= 24'h00_0004;
    wait_xfers(2, 2);
    settle();
    want <= 24'h00_0000;
    check(model.xfers[2], 32'h0000_0002);
    check(model.irqs[2], 32'h0000_0001);
    rdc(TCM_OFF_ENABLE0, 32'h0000_0000);
    rdc(TCM_OFF_COUNT, 32'h0000_0005);
    rdc(TCM_OFF_ADDR, 32'h0000_0102);
    check({16'h0000, maddr}, 32'h0000_0102);
    irq_is(1'b1);
    wrt(TCM_OFF_STATUS, 32'h0000_0004);
    irq_is(1'b0);
    wrt(TCM_OFF_MASK, 32'h0000_0000);
    $display("test repeat interrupt done");
    // Highest set, bit 7 of the third enable register
    wrt(TCM_OFF_SEL, 32'h0000_0017);
    wrt(TCM_OFF_COUNT, 32'h0000_0001);
    wrt(8'h08, 32'h0000_0080);
    want <= 24'h80_0000;
    wait_xfers(23, 1);
    settle();
    want <= 24'h00_0000;
    check(model.irqs[23], 32'h0000_0001);
    rdc(8'h08, 32'h0000_0000);
    rdc(TCM_OFF_COUNT, 32'h0000_0000);
    $display("test last set done");
    // Reset while the controller is idle returns the registers to their reset values
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    rdc(TCM_OFF_MODE, 32'h0000_0000);
    rdc(TCM_OFF_RPT_IE, 32'h0000_0000);
    rdc(TCM_OFF_SEL, 32'h0000_0000);
    $display("test reset done");
    test_done();
  end
endmodule : tcm_top_bench
